// file: gtcb_pkg.sv
package gtcb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clocking and timing
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned TICK_MS         = 100;
   localparam int unsigned UART_OVERSAMPLE = 16;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CMD    = 8'h00;
   localparam logic [7:0] OFS_RESP   = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_TRAIL  = 8'h0c;
   localparam logic [7:0] OFS_LEAD   = 8'h10;
   localparam logic [7:0] OFS_SEQ    = 8'h14;
   localparam logic [7:0] OFS_RATE   = 8'h18;
   localparam logic [7:0] OFS_SRC    = 8'h1c;
   localparam logic [7:0] OFS_DIV    = 8'h20;
   localparam logic [7:0] OFS_RADIO  = 8'h24;

   ////////////////////////////////////////////////////////////////////////////
   // command word layout and response bits
   localparam int unsigned CMD_OP_LSB   = 0;
   localparam int unsigned CMD_PRM_LSB  = 8;
   localparam int unsigned CMD_HAS_BIT  = 24;
   localparam int unsigned RESP_DONE    = 16;
   localparam int unsigned RESP_REJ     = 17;
   localparam int unsigned STAT_CMDMODE = 0;
   localparam int unsigned STAT_PEND    = 1;

   ////////////////////////////////////////////////////////////////////////////
   // binary opcodes
   localparam logic [7:0] OP_AUTO_ADDR = 8'h3a;
   localparam logic [7:0] OP_TRAIL     = 8'h05;
   localparam logic [7:0] OP_RATE      = 8'h15;
   localparam logic [7:0] OP_LEAD      = 8'h04;
   localparam logic [7:0] OP_SEQ       = 8'h13;
   localparam logic [7:0] OP_EXIT      = 8'h09;

   ////////////////////////////////////////////////////////////////////////////
   // parameter ranges and defaults
   localparam logic [15:0] GUARD_MIN    = 16'h0002;
   localparam logic [15:0] GUARD_DEF    = 16'h000a;
   localparam logic [7:0]  SEQ_MIN      = 8'h20;
   localparam logic [7:0]  SEQ_MAX      = 8'h7f;
   localparam logic [7:0]  SEQ_DEF      = 8'h2b;
   localparam logic [15:0] RATE_STD_MAX = 16'h0006;
   localparam logic [15:0] RATE_NS_MIN  = 16'h007d;

   ////////////////////////////////////////////////////////////////////////////
   // serial number bits forming the source address
   localparam int unsigned SN_BIT_A  = 29;
   localparam int unsigned SN_BIT_B  = 28;
   localparam int unsigned SN_LO_MSB = 13;

   typedef enum logic [1:0] {ST_LEAD, ST_CHAR, ST_TRAIL, ST_CMD} gtcb_state_e;

endpackage

// file: gtcb_top.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module gtcb_top
   import gtcb_pkg::*;
#(
   parameter int unsigned  TICK_CYC        = CLK_HZ / 1000 * TICK_MS,
   parameter int unsigned  UART_REF_HZ     = CLK_HZ / UART_OVERSAMPLE,
   parameter logic [15:0]  RADIO_RATE_CODE = 16'h0003
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   input  wire logic        host_byte_valid,
   input  wire logic [7:0]  host_byte,
   input  wire logic [31:0] serial_number,
   output logic             cmd_mode,
   output logic      [15:0] host_rate_div,
   output logic      [15:0] radio_rate_code,
   output logic      [15:0] source_address
);

   ////////////////////////////////////////////////////////////////////////////
   // rate arithmetic

   function automatic logic [31:0] rate_std(input logic [15:0] code);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (code[2:0])
         3'h0: r = 32'd1200;
         3'h1: r = 32'd2400;
         3'h2: r = 32'd4800;
         3'h3: r = 32'd9600;
         3'h4: r = 32'd19200;
         3'h5: r = 32'd38400;
         3'h6: r = 32'd57600;
         3'h7: r = 32'd57600;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] div_round(input logic [31:0] r);
      logic [31:0] ref_hz;
      ref_hz = 32'(UART_REF_HZ);
      return (ref_hz + (r >> 1)) / r;
   endfunction

   function automatic logic [15:0] div_of_setting(input logic [15:0] s);
      logic [31:0] d;
      d = (s <= RATE_STD_MAX) ? div_round(rate_std(s)) : div_round({16'h0000, s});
      return d[15:0];
   endfunction

   // closest rate the divider can really produce
   function automatic logic [15:0] snap_rate(input logic [15:0] s);
      logic [31:0] d;
      logic [31:0] q;
      d = div_round({16'h0000, s});
      q = (32'(UART_REF_HZ) + (d >> 1)) / d;
      return (q > 32'h0000_ffff) ? 16'hffff : q[15:0];
   endfunction

   localparam logic [15:0] DIV_RST = div_of_setting(RADIO_RATE_CODE);

   ////////////////////////////////////////////////////////////////////////////
   // command decode

   logic        cmd_wr;
   logic [7:0]  op;
   logic [15:0] prm;
   logic        has_prm;
   logic        guard_ok;
   logic        seq_ok;
   logic        rate_ok;

   assign cmd_wr   = wr && (addr == OFS_CMD);
   assign op       = wdata[CMD_OP_LSB +: 8];
   assign prm      = wdata[CMD_PRM_LSB +: 16];
   assign has_prm  = wdata[CMD_HAS_BIT];
   assign guard_ok = prm >= GUARD_MIN;
   assign seq_ok   = (prm[15:8] == 8'h00) && (prm[7:0] >= SEQ_MIN) && (prm[7:0] <= SEQ_MAX);
   assign rate_ok  = (prm <= RATE_STD_MAX) || (prm >= RATE_NS_MIN);

   logic        do_exit;
   assign do_exit = cmd_wr && (op == OP_EXIT);

   // command word that writes a legal parameter for one opcode
   function automatic logic set_cmd(input logic       w,
                                    input logic [7:0] o,
                                    input logic [7:0] code,
                                    input logic       has,
                                    input logic       legal);
      return w && (o == code) && has && legal;
   endfunction

   logic        set_trail;
   logic        set_lead;
   logic        set_seq;
   logic        set_rate;

   assign set_trail = set_cmd(cmd_wr, op, OP_TRAIL, has_prm, guard_ok);
   assign set_lead  = set_cmd(cmd_wr, op, OP_LEAD, has_prm, guard_ok);
   assign set_seq   = set_cmd(cmd_wr, op, OP_SEQ, has_prm, seq_ok);
   assign set_rate  = set_cmd(cmd_wr, op, OP_RATE, has_prm, rate_ok);

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic [15:0] trail_guard_r;
   logic [15:0] leading_guard_time_r;
   logic [7:0]  sequence_character_r;
   logic [15:0] host_bit_rate_setting_r;
   logic        rate_pend_r;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         trail_guard_r <= GUARD_DEF;
      end else if (set_trail) begin
         trail_guard_r <= prm;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         leading_guard_time_r <= GUARD_DEF;
      end else if (set_lead) begin
         leading_guard_time_r <= prm;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sequence_character_r <= SEQ_DEF;
      end else if (set_seq) begin
         sequence_character_r <= prm[7:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         host_bit_rate_setting_r <= RADIO_RATE_CODE;
      end else if (set_rate) begin
         host_bit_rate_setting_r <= (prm <= RATE_STD_MAX) ? prm : snap_rate(prm);
      end
   end

   // old divider stays in use until exit
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rate_pend_r   <= 1'b0;
         host_rate_div <= DIV_RST;
      end else if (do_exit) begin
         rate_pend_r   <= 1'b0;
         host_rate_div <= div_of_setting(host_bit_rate_setting_r);
      end else if (set_rate) begin
         rate_pend_r <= 1'b1;
      end
   end

   // radio rate never touched by host rate commands
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         radio_rate_code <= RADIO_RATE_CODE;
      end else begin
         radio_rate_code <= RADIO_RATE_CODE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         source_address <= 16'hffff;
      end else if (cmd_wr && (op == OP_AUTO_ADDR)) begin
         source_address <= {serial_number[SN_BIT_A], serial_number[SN_BIT_B],
                            serial_number[SN_LO_MSB:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // query response

   logic [31:0] resp_r;
   logic [31:0] resp_nxt;

   always_comb begin
      resp_nxt = resp_r;
      if (cmd_wr) begin
         resp_nxt = 32'h0000_0000;
         resp_nxt[RESP_DONE] = 1'b1;
         unique case (op)
            OP_TRAIL: begin
               resp_nxt[15:0]     = has_prm ? prm : trail_guard_r;
               resp_nxt[RESP_REJ] = has_prm && !guard_ok;
            end
            OP_LEAD: begin
               resp_nxt[15:0]     = has_prm ? prm : leading_guard_time_r;
               resp_nxt[RESP_REJ] = has_prm && !guard_ok;
            end
            OP_RATE: begin
               resp_nxt[15:0]     = has_prm ? prm : host_bit_rate_setting_r;
               resp_nxt[RESP_REJ] = has_prm && !rate_ok;
            end
            OP_SEQ: begin
               resp_nxt[15:0]     = has_prm ? prm : {8'h00, sequence_character_r};
               resp_nxt[RESP_REJ] = has_prm && !seq_ok;
            end
            OP_AUTO_ADDR, OP_EXIT: begin
               resp_nxt[15:0] = 16'h0000;
            end
            default: begin
               resp_nxt[RESP_REJ] = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         resp_r <= 32'h0000_0000;
      end else begin
         resp_r <= resp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // entry sequence detection

   gtcb_state_e state_r;
   gtcb_state_e state_nxt;
   logic        restart;
   logic [31:0] tick_cnt_r;
   logic [15:0] units_r;
   logic        tick;

   assign tick = tick_cnt_r == 32'(TICK_CYC - 1);

   always_comb begin
      state_nxt = state_r;
      restart   = 1'b0;
      unique case (state_r)
         ST_LEAD: begin
            if (host_byte_valid) begin
               restart = 1'b1;
            end else if (units_r >= leading_guard_time_r) begin
               state_nxt = ST_CHAR;
            end
         end
         ST_CHAR: begin
            if (host_byte_valid) begin
               restart   = 1'b1;
               state_nxt = (host_byte == sequence_character_r) ? ST_TRAIL : ST_LEAD;
            end
         end
         ST_TRAIL: begin
            if (host_byte_valid) begin
               restart   = 1'b1;
               state_nxt = ST_LEAD;
            end else if (units_r >= trail_guard_r) begin
               state_nxt = ST_CMD;
            end
         end
         ST_CMD: begin
            if (do_exit) begin
               restart   = 1'b1;
               state_nxt = ST_LEAD;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_r <= ST_LEAD;
      end else begin
         state_r <= state_nxt;
      end
   end

   // silence timer in 100 ms units, saturating
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tick_cnt_r <= 32'h0000_0000;
         units_r    <= 16'h0000;
      end else if (restart) begin
         tick_cnt_r <= 32'h0000_0000;
         units_r    <= 16'h0000;
      end else if (tick) begin
         tick_cnt_r <= 32'h0000_0000;
         if (units_r != 16'hffff) begin
            units_r <= units_r + 16'h0001;
         end
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cmd_mode <= 1'b0;
      end else begin
         cmd_mode <= state_nxt == ST_CMD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         unique case (addr)
            OFS_RESP:   rdata <= resp_r;
            OFS_STATUS: rdata <= {30'h0000_0000, rate_pend_r, state_r == ST_CMD};
            OFS_TRAIL:  rdata <= {16'h0000, trail_guard_r};
            OFS_LEAD:   rdata <= {16'h0000, leading_guard_time_r};
            OFS_SEQ:    rdata <= {24'h00_0000, sequence_character_r};
            OFS_RATE:   rdata <= {16'h0000, host_bit_rate_setting_r};
            OFS_SRC:    rdata <= {16'h0000, source_address};
            OFS_DIV:    rdata <= {16'h0000, host_rate_div};
            OFS_RADIO:  rdata <= {16'h0000, radio_rate_code};
            default:    rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

endmodule

// file: gtcb_props.sv
`timescale 1ns/10ps
module gtcb_props
   import gtcb_pkg::*;
#(
   parameter int unsigned TICK_CYC        = 10,
   parameter logic [15:0] RADIO_RATE_CODE = 16'h0003
) (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        host_byte_valid,
   input wire logic [31:0] serial_number,
   input wire logic        cmd_mode,
   input wire logic [15:0] host_rate_div,
   input wire logic [15:0] radio_rate_code,
   input wire logic [15:0] source_address
);
   logic [31:0] quiet_r;
   logic        exit_w;

   assign exit_w = wr && addr == OFS_CMD && wdata[7:0] == OP_EXIT;

   // cycles since the last serial byte
   always_ff @(posedge clk_sys) begin
      if (!rstn || host_byte_valid) begin
         quiet_r <= '0;
      end else if (quiet_r != '1) begin
         quiet_r <= quiet_r + 32'h1;
      end
   end

   default clocking dcb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence stat_rd_s;
      rd && addr == OFS_STATUS ##1 $stable(cmd_mode);
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   rd_idle_a: assert property (!$past(rd) |-> rdata == '0)
      else $error("read data not idle");
   stat_echo_a: assert property (stat_rd_s |-> rdata[STAT_CMDMODE] == cmd_mode)
      else $error("status mode bit wrong");
   src_cause_a: assert property ($changed(source_address) |-> $past(wr && wdata[7:0] == OP_AUTO_ADDR))
      else $error("source address changed unasked");
   src_value_a: assert property ($changed(source_address) |->
      source_address == {serial_number[SN_BIT_A], serial_number[SN_BIT_B], serial_number[SN_LO_MSB:0]})
      else $error("source address bits wrong");
   radio_fixed_a: assert property (radio_rate_code == RADIO_RATE_CODE)
      else $error("radio rate moved");
   div_exit_a: assert property ($changed(host_rate_div) |-> $past(exit_w))
      else $error("divider changed before exit");
   mode_fall_a: assert property ($fell(cmd_mode) |-> $past(exit_w))
      else $error("command mode left without exit");
   mode_hold_a: assert property (cmd_mode && !exit_w |=> cmd_mode)
      else $error("command mode dropped");
   entry_quiet_a: assert property ($rose(cmd_mode) |-> quiet_r >= GUARD_MIN * TICK_CYC)
      else $error("entry without trailing silence");
endmodule

bind gtcb_top gtcb_props #(.TICK_CYC(TICK_CYC), .RADIO_RATE_CODE(RADIO_RATE_CODE)) props (
   .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .host_byte_valid(host_byte_valid), .serial_number(serial_number),
   .cmd_mode(cmd_mode), .host_rate_div(host_rate_div), .radio_rate_code(radio_rate_code),
   .source_address(source_address));

// file: gtcb_host_model.sv
`timescale 1ns/10ps
module gtcb_host_model #(
   parameter int unsigned TICK_CYC = 10
) (
   input  wire logic       clk_sys,
   output logic            host_byte_valid,
   output logic      [7:0] host_byte
);
   initial begin
      host_byte_valid = 1'b0;
      host_byte = 8'h00;
   end

   // one byte; line shows junk once released
   task automatic send(input logic [7:0] b);
      @(posedge clk_sys);
      host_byte_valid <= 1'b1;
      host_byte <= b;
      @(posedge clk_sys);
      host_byte_valid <= 1'b0;
      host_byte <= ~b;
   endtask

   // keep the line silent for n ticks
   task automatic quiet(input int n);
      repeat (n * TICK_CYC) @(posedge clk_sys);
   endtask
endmodule

// file: tb.sv
`timescale 1ns/10ps
module tb;
   import gtcb_pkg::*;
   localparam int TCK = 10;
   localparam int REF = 6_250_000;
   logic        clk_sys;
   logic        rstn;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        host_byte_valid;
   logic [7:0]  host_byte;
   logic [31:0] serial_number;
   logic        cmd_mode;
   logic [15:0] host_rate_div;
   logic [15:0] radio_rate_code;
   logic [15:0] source_address;
   logic [31:0] v;
   int          bad_count;
   int          num_checks;
   int          cyc;
   int          n;

   gtcb_top #(.TICK_CYC(TCK), .UART_REF_HZ(REF), .RADIO_RATE_CODE(16'h0003)) dut (
      .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .host_byte_valid(host_byte_valid), .host_byte(host_byte),
      .serial_number(serial_number), .cmd_mode(cmd_mode), .host_rate_div(host_rate_div),
      .radio_rate_code(radio_rate_code), .source_address(source_address));
   gtcb_host_model #(.TICK_CYC(TCK)) host (
      .clk_sys(clk_sys), .host_byte_valid(host_byte_valid), .host_byte(host_byte));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] div_of(input int r);
      return (REF + r / 2) / r;
   endfunction

   function automatic logic [31:0] snap(input int r);
      return (REF + div_of(r) / 2) / div_of(r);
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         $display("mismatch at %0t: timeout", $time);
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic cmd(input logic [7:0] op, input logic [15:0] p, input logic has);
      bus_wr(OFS_CMD, {7'h00, has, p, op});
      bus_rd(OFS_RESP);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      bus_rd(OFS_TRAIL);
      chk(v, 32'h0000000a);
      bus_rd(OFS_LEAD);
      chk(v, 32'h0000000a);
      bus_rd(OFS_SEQ);
      chk(v, 32'h0000002b);
      bus_rd(OFS_RATE);
      chk(v, 32'h00000003);
      bus_rd(8'h3c);
      chk(v, 32'h00000000);
      bus_rd(OFS_RADIO);
      chk(v, 32'h00000003);
      chk(host_rate_div, div_of(9600));
      chk(source_address, 32'h0000ffff);
      $display("test reset done");
   endtask

   task automatic t_addr();
      cmd(OP_AUTO_ADDR, 16'h0000, 1'b0);
      chk(source_address, {serial_number[29], serial_number[28], serial_number[13:0]});
      bus_rd(OFS_SRC);
      chk(v, 32'h00009234);
      $display("test address done");
   endtask

   task automatic t_guard();
      cmd(OP_TRAIL, 16'h0001, 1'b1);
      chk(v[17], 1'b1);
      cmd(OP_TRAIL, GUARD_MIN, 1'b1);
      chk(v, 32'h00010002);
      cmd(OP_LEAD, GUARD_MIN, 1'b1);
      cmd(OP_LEAD, 16'h0000, 1'b0);
      chk(v, 32'h00010002);
      cmd(OP_TRAIL, 16'h0000, 1'b0);
      chk(v, 32'h00010002);
      cmd(OP_SEQ, 16'h001f, 1'b1);
      chk(v[17], 1'b1);
      cmd(OP_SEQ, 16'h0000, 1'b0);
      chk(v, 32'h0001002b);
      cmd(8'h7e, 16'h0000, 1'b0);
      chk(v[17:16], 2'b11);
      $display("test guard done");
   endtask

   task automatic t_entry();
      host.quiet(3);
      host.send(SEQ_DEF);
      host.quiet(1);
      host.send(8'h41);
      host.quiet(3);
      chk(cmd_mode, 1'b0);
      host.send(SEQ_DEF);
      n = 0;
      while (cmd_mode !== 1'b1 && n < 4 * TCK) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(cmd_mode, 1'b1);
      chk(n >= 2 * TCK - 1, 1'b1);
      chk(n <= 2 * TCK + 4, 1'b1);
      bus_rd(OFS_STATUS);
      chk(v[STAT_CMDMODE], 1'b1);
      $display("test entry done");
   endtask

   task automatic t_rate();
      for (int c = 0; c <= 6; c++) begin
         cmd(OP_RATE, c[15:0], 1'b1);
         bus_rd(OFS_RATE);
         chk(v, c);
      end
      cmd(OP_RATE, 16'h007c, 1'b1);
      chk(v[17], 1'b1);
      cmd(OP_RATE, RATE_NS_MIN, 1'b1);
      chk(v[17], 1'b0);
      cmd(OP_RATE, 16'he100, 1'b1);
      cmd(OP_RATE, 16'h0000, 1'b0);
      chk(v[15:0], snap(57600));
      chk(host_rate_div, div_of(9600));
      chk(radio_rate_code, 32'h00000003);
      bus_rd(OFS_STATUS);
      chk(v, 32'h00000003);
      bus_wr(OFS_CMD, {24'h000000, OP_EXIT});
      #1;
      chk(cmd_mode, 1'b0);
      chk(host_rate_div, div_of(57600));
      bus_rd(OFS_STATUS);
      chk(v, 32'h00000000);
      bus_rd(OFS_DIV);
      chk(v, div_of(57600));
      chk(radio_rate_code, 32'h00000003);
      $display("test rate done");
   endtask

   initial begin
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 32'h00000000;
      wr = 1'b0;
      rd = 1'b0;
      serial_number = 32'h2abc1234;
      bad_count = 0;
      num_checks = 0;
      cyc = 0;
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_addr();
      t_guard();
      t_entry();
      t_rate();
      test_done();
   end
endmodule
